// ===== bench/ssw_ctrl_model.sv
// controller model that drives the port's write and load pins
`timescale 1ns/1ps
module ssw_ctrl_model
    import ssw_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             qual_n_i,
    input  wire logic             sel_i,
    input  wire logic             wr_i,
    input  wire logic             adv_i,
    input  wire logic [LANES-1:0] lanes_i,
    output logic                  write_n_o,
    output logic                  adv_o,
    output logic [LANES-1:0]      lanes_n_o
);
    logic desel_reg;
    // a stalled edge is not seen by the sram, so it must not move our view either
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            desel_reg <= 1'b1;
        end else if (!qual_n_i) begin
            desel_reg <= ~sel_i;
        end
    end
    // lanes stay driven without a write, so the port must ignore them itself
    assign write_n_o = ~(wr_i & sel_i);
    assign adv_o     = adv_i & ~desel_reg;
    assign lanes_n_o = ~lanes_i;
endmodule : ssw_ctrl_model

// ===== bench/testbench.sv
// self-checking bench for the sram address and write port
`timescale 1ns/1ps
module testbench
    import ssw_pkg::*;
;
    logic                  clk_i = 1'b0;
    logic                  rst_n_i, sel, wr, adv, qual_n, order, write_n, adv_pin;
    logic                  wr_o, rd_o, allow, desel;
    logic [LANES-1:0]      lanes, lanes_n, lane_wr;
    logic [ADDR_WIDTH-1:0] addr, word_addr, base;
    logic [1:0]            op, cnt;
    logic [23:0]           pipe [4];
    logic [23:0]           got;
    int                    fail_count = 0;
    int                    checks_done = 0;
    always #12.5 clk_i = ~clk_i;
    ssw_ctrl_model i_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .qual_n_i(qual_n), .sel_i(sel),
        .wr_i(wr), .adv_i(adv), .lanes_i(lanes), .write_n_o(write_n), .adv_o(adv_pin),
        .lanes_n_o(lanes_n));
    ssw_port i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .byte_lane_write_n_i(lanes_n), .write_n_i(write_n), .clock_qualifier_n_i(qual_n),
        .advance_or_load_i(adv_pin), .chip_select_i(sel), .burst_order_i(order),
        .word_addr_o(word_addr), .lane_write_o(lane_wr), .write_o(wr_o), .read_o(rd_o),
        .data_out_allow_o(allow));
    // the address only matters on a read or write cycle
    assign got = {lane_wr, wr_o, rd_o, allow, (wr_o | rd_o) ? word_addr : 19'h00000};
    // expected outputs of one accepted cycle; op 1 is read, 2 is write
    function automatic logic [23:0] expect_out(input logic [1:0] o, input logic [1:0] ln,
            input logic ds, input logic [18:0] b, input logic [1:0] c, input logic il);
        logic [1:0] offs;
        offs = il ? (b[1:0] ^ c) : (b[1:0] + c);
        if (o == 2'h0) return 24'h000000;
        return {(o == 2'h2) ? ln : 2'h0, o == 2'h2, o == 2'h1, o == 2'h1 && !ds, b[18:2], offs};
    endfunction : expect_out
    // reference model, four edges from drive to output
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pipe = '{default: 24'h000000};
            op = 2'h0;
            cnt = 2'h0;
            desel = 1'b1;
            base = 19'h00000;
        end else begin
            pipe[3] = pipe[2];
            pipe[2] = pipe[1];
            pipe[1] = pipe[0];
            pipe[0] = 24'h000000;
            if (!qual_n && !sel) begin
                desel = 1'b1;
                op = 2'h0;
            end else if (!qual_n) begin
                if (!adv_pin) begin
                    base = addr;
                    cnt = 2'h0;
                    op = write_n ? 2'h1 : 2'h2;
                end else cnt = cnt + 2'h1;
                pipe[0] = expect_out(op, ~lanes_n, desel, base, cnt, order);
                desel = 1'b0;
            end
        end
    end
    always @(negedge clk_i) begin
        if (rst_n_i) begin
            checks_done++;
            if (got !== pipe[3]) begin
                fail_count++;
                $display("wrong value at %0t: got %h expected %h", $time, got, pipe[3]);
            end
        end
    end
    task automatic drive(input logic s, input logic w, input logic a, input logic q,
            input logic [18:0] ad);
        @(posedge clk_i);
        sel <= s;
        wr <= w;
        adv <= a;
        qual_n <= q;
        addr <= ad;
        lanes <= 2'($urandom);
    endtask : drive
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // watchdog, about twice the expected run
    initial begin
        #(25.0 * 6000);
        fail_count++;
        finish_test();
    end
    initial begin
        {sel, wr, adv, qual_n, order, rst_n_i, lanes, addr} = {6'h0c, 2'h0, 19'h00000};
        void'($urandom(76912));
        // phase 0 interleaved, phase 1 linear after a second reset
        for (int ph = 0; ph < 2; ph++) begin
            @(posedge clk_i);
            rst_n_i <= 1'b0;
            order <= (ph == 0);
            repeat (10) @(posedge clk_i);
            rst_n_i <= 1'b1;
            // burst wrapping from offset 3 with a stall inside, then deselect
            drive(1'b1, 1'b1, 1'b0, 1'b0, 19'h7fffb);
            drive(1'b1, 1'b1, 1'b1, 1'b0, 19'h00000);
            drive(1'b1, 1'b1, 1'b1, 1'b1, 19'h00000);
            drive(1'b1, 1'b0, 1'b1, 1'b0, 19'h00000);
            drive(1'b1, 1'b0, 1'b0, 1'b0, 19'h00002);
            drive(1'b0, 1'b0, 1'b0, 1'b0, 19'h00000);
            drive(1'b1, 1'b0, 1'b1, 1'b0, 19'h12345);
            repeat (1500) drive($urandom % 8 != 0, 1'($urandom), 1'($urandom),
                $urandom % 4 == 0, 19'($urandom));
        end
        repeat (6) drive(1'b0, 1'b0, 1'b0, 1'b0, 19'h00000);
        finish_test();
    end
endmodule : testbench

// ===== verilog/ssw_burst_counter.sv
// two-bit burst counter with linear or interleaved sequence
`timescale 1ns/1ps
module ssw_burst_counter
    import ssw_pkg::*;
#(
    parameter int WIDTH = BURST_WIDTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             load_i,
    input  wire logic             adv_i,
    input  wire logic             interleave_i,
    input  wire logic [WIDTH-1:0] seed_i,
    output logic      [WIDTH-1:0] offset_o
);
    logic [WIDTH-1:0] seed_reg;
    logic [WIDTH-1:0] step_reg;
    logic [WIDTH-1:0] step_next;

    // step counts burst beats; offset is seed plus or xor step
    assign step_next = step_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    assign offset_o  = interleave_i ? (seed_reg ^ step_reg)
                                    : WIDTH'(seed_reg + step_reg); // [R8]

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seed_reg <= '0;
            step_reg <= '0;
        end else if (load_i) begin
            seed_reg <= seed_i; // [R2]
            step_reg <= '0;
        end else if (adv_i) begin
            step_reg <= step_next; // [R2]
        end
    end
endmodule : ssw_burst_counter

// ===== verilog/ssw_pkg.sv
// package of constants for the synchronous sram write/address port
package ssw_pkg;
    localparam int ADDR_WIDTH   = 19;   // 512K word locations
    localparam int BURST_WIDTH  = 2;    // two-bit burst counter
    localparam int LANES        = 2;    // two byte lanes
    localparam int LANE_WIDTH   = 9;    // eight data bits plus parity
    localparam int DATA_WIDTH   = LANES * LANE_WIDTH;
    localparam logic [BURST_WIDTH-1:0] BURST_RESET = 2'h0;
    localparam logic [ADDR_WIDTH-1:0]  ADDR_RESET  = 19'h00000;
    localparam logic [LANES-1:0]       LANE_OFF_N  = 2'h3;
    typedef enum logic [1:0] {SSW_IDLE, SSW_READ, SSW_WRITE} ssw_op_type;
endpackage : ssw_pkg

// ===== verilog/ssw_port.sv
// address, byte-write and control input port of a flow-through burst sram
// Summary of operation
// R1: capture the address on each qualified load edge, selecting one of 512K words
// R2: two lowest address bits seed the two-bit burst counter
// R3: byte-lane selects write only their lanes, and only with write enable low
// R4: write enable is sampled only at edges with clock qualifier low
// R5: controller drives write enable low to start a write; high means no write
// R6: clock qualifier high freezes all state, extending the previous cycle; here the outputs show no access for a frozen edge
// R7: advance_or_load high advances the counter, low loads a new address
// R8: burst order strap low gives linear, high gives interleaved
// R9: data outputs off during write data, first cycle after deselect, and deselect
`timescale 1ns/1ps
module ssw_port
    import ssw_pkg::*;
#(
    parameter int AW = ADDR_WIDTH,
    parameter int NL = LANES
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [NL-1:0] byte_lane_write_n_i,   // lane0 is bit 0, lane1 bit 1
    input  wire logic          write_n_i,
    input  wire logic          clock_qualifier_n_i,
    input  wire logic          advance_or_load_i,
    input  wire logic          chip_select_i,         // combined chip enables
    input  wire logic          burst_order_i,         // strap, 1 = interleaved
    output logic [AW-1:0]      word_addr_o,
    output logic [NL-1:0]      lane_write_o,
    output logic               write_o,
    output logic               read_o,
    output logic               data_out_allow_o
);
    // pins come from the controller's domain: two flops before any logic
    logic [AW-1:0] addr_s1_reg, addr_s2_reg;
    logic [NL-1:0] bw_s1_reg, bw_s2_reg;
    logic [4:0]    ctl_s1_reg, ctl_s2_reg;
    logic          strap_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_s1_reg <= '0;
            addr_s2_reg <= '0;
            bw_s1_reg   <= LANE_OFF_N;
            bw_s2_reg   <= LANE_OFF_N;
            ctl_s1_reg  <= 5'h03;
            ctl_s2_reg  <= 5'h03;
        end else begin
            addr_s1_reg <= addr_i;
            addr_s2_reg <= addr_s1_reg;
            bw_s1_reg   <= byte_lane_write_n_i;
            bw_s2_reg   <= bw_s1_reg;
            ctl_s1_reg  <= {burst_order_i, chip_select_i, advance_or_load_i,
                            clock_qualifier_n_i, write_n_i};
            ctl_s2_reg  <= ctl_s1_reg;
        end
    end

    // decoded synchronised controls
    wire qual_w    = ~ctl_s2_reg[1];
    wire we_w      = ~ctl_s2_reg[0];
    wire adv_w     = ctl_s2_reg[2];
    wire sel_w     = ctl_s2_reg[3];
    wire load_w    = qual_w & ~adv_w & sel_w;          // [R7]
    wire advance_w = qual_w & adv_w;                   // [R7]

    // strap caught once the sync pair holds a real pin sample, then held;
    // catching it any earlier would take the flops' reset value, not the pin
    logic [1:0] strap_age_reg;
    logic       strap_done_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_reg      <= 1'b1;
            strap_age_reg  <= 2'h0;
            strap_done_reg <= 1'b0;
        end else begin
            strap_age_reg <= {strap_age_reg[0], 1'b1};
            if (strap_age_reg[1] && !strap_done_reg) begin
                strap_reg      <= ctl_s2_reg[4]; // [R8]
                strap_done_reg <= 1'b1;
            end
        end
    end

    // base address and operation registers; all frozen when unqualified
    logic [AW-1:0] base_reg;
    ssw_op_type    op_reg, op_next;
    logic          desel_reg;
    logic          fresh_reg;
    logic [NL-1:0] lanes_reg;

    // a write needs write enable at a qualified edge; advance keeps the type
    assign op_next = !sel_w ? SSW_IDLE
                   : adv_w  ? op_reg
                   : (we_w  ? SSW_WRITE : SSW_READ);   // [R4] [R5]

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            base_reg  <= ADDR_RESET;
            op_reg    <= SSW_IDLE;
            desel_reg <= 1'b1;
            fresh_reg <= 1'b0;
            lanes_reg <= '0;
        end else if (qual_w) begin                     // [R6]
            if (load_w) begin
                base_reg <= addr_s2_reg;               // [R1]
            end
            op_reg    <= op_next;
            desel_reg <= ~sel_w;
            fresh_reg <= desel_reg & sel_w;            // first cycle out of deselect
            lanes_reg <= (op_next == SSW_WRITE) ? ~bw_s2_reg : '0; // [R3]
        end
    end

    // remembers whether the edge that last touched the state was qualified;
    // the live qualifier already belongs to the next cycle, so gating the
    // outputs with it would report a frozen cycle as an access
    logic act_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_reg <= 1'b0;
        end else begin
            act_reg <= qual_w; // [R6]
        end
    end

    // the offset follows the held strap; a strap moved after reset is ignored
    // until the next reset, since the pin is meant to be tied
    logic [BURST_WIDTH-1:0] offset_w;
    ssw_burst_counter #(.WIDTH(BURST_WIDTH)) u_burst (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .load_i       (load_w),
        .adv_i        (advance_w),
        .interleave_i (strap_reg),
        .seed_i       (addr_s2_reg[BURST_WIDTH-1:0]),  // [R2]
        .offset_o     (offset_w)
    );

    // outputs registered straight from flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_addr_o      <= ADDR_RESET;
            lane_write_o     <= '0;
            write_o          <= 1'b0;
            read_o           <= 1'b0;
            data_out_allow_o <= 1'b0;
        end else begin
            word_addr_o      <= {base_reg[AW-1:BURST_WIDTH], offset_w};
            lane_write_o     <= (op_reg == SSW_WRITE && act_reg) ? lanes_reg : '0; // [R3]
            write_o          <= (op_reg == SSW_WRITE) && act_reg; // [R4]
            read_o           <= (op_reg == SSW_READ) && act_reg;
            data_out_allow_o <= (op_reg == SSW_READ) && act_reg && !desel_reg
                                && !fresh_reg;         // [R9]
        end
    end

    // checks below, but for a_lane_needs_write, a_data_off and a_write_no_drive, watch
    // the synchronised controls, so their antecedents sit two edges after the pins that cause them

    // a_lane_needs_write: lanes never strobe without a write
    a_lane_needs_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
        (lane_write_o != '0) |-> write_o) else $error("lane write without write");

    // a_freeze_hold: unqualified edge keeps base
    a_freeze_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        !qual_w |=> $stable(base_reg)) else $error("state moved while frozen");

    // a_stall_offset: unqualified edge keeps the burst position once the strap is held
    a_stall_offset: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
        !qual_w && strap_done_reg |=> $stable(offset_w))
        else $error("burst moved while frozen");

    // a_frozen_quiet: an unqualified edge yields no access two edges later
    sequence s_frozen;
        !qual_w;
    endsequence
    a_frozen_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4] [R6]
        s_frozen |-> ##2 (!write_o && !read_o && lane_write_o == '0 && !data_out_allow_o))
        else $error("access from a frozen edge");

    // a_load_addr: qualified load captures address
    a_load_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
        load_w |=> base_reg == $past(addr_s2_reg)) else $error("address not loaded");

    // a_load_seed: a load restarts the burst at the two low address bits
    a_load_seed: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
        load_w |=> offset_w == base_reg[BURST_WIDTH-1:0])
        else $error("burst seed not loaded");

    // a_write_start: write op only from write enable low
    sequence s_wr_load;
        qual_w && sel_w && !adv_w && !we_w;
    endsequence
    a_write_start: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4] [R5]
        s_wr_load |=> op_reg != SSW_WRITE) else $error("write without enable");

    // a_write_load: a load with write enable low becomes a write
    sequence s_wr_req;
        qual_w && sel_w && !adv_w && we_w;
    endsequence
    a_write_load: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4] [R5]
        s_wr_req |=> op_reg == SSW_WRITE) else $error("write enable not taken");

    // a_burst_step: advance moves offset by one in linear mode
    a_burst_step: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2] [R7] [R8]
        advance_w && !strap_reg |=> offset_w == BURST_WIDTH'($past(offset_w) + 2'h1))
        else $error("burst did not step");

    // a_data_off: no drive when deselected
    a_data_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        desel_reg |=> !data_out_allow_o) else $error("drive while deselected");

    // a_desel_idle: a qualified deselect ends any access
    a_desel_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        qual_w && !sel_w |=> op_reg == SSW_IDLE) else $error("access kept after deselect");

    // a_first_off: first selected edge out of deselect never drives data
    a_first_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        qual_w && sel_w && desel_reg |-> ##2 !data_out_allow_o)
        else $error("drive on first cycle after deselect");

    // a_write_no_drive: no drive during write
    a_write_no_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
        write_o |-> !data_out_allow_o) else $error("drive during write");

    // a_interleave_order: xor order after load
    a_interleave_order: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
        load_w ##1 (advance_w && strap_reg) |=> offset_w == (base_reg[1:0] ^ 2'h1))
        else $error("interleave order wrong");
endmodule : ssw_port
